// ### logic/pslv_parallel_slave_port.sv
// parallel slave port on port D/E with an APB register slave
// Overview of operation
// - enable bit set turns port D into an 8-bit parallel slave port
// - port E pins 0,1,2 become read strobe, write strobe, chip select (low)
// - two 8-bit latches share one address: firmware writes out, reads in
// - port D direction register is ignored in slave-port mode
// - external write starts on chip select and write strobe both low
// - write end sets input-full on phase four after the next phase two
// - write end sets interrupt flag in the same cycle as input-full
// - input-full clears when firmware reads the port D input latch or the mode is disabled
// - second external write with input unread sets input-overrun flag
// - external read start immediately clears output-full flag
// - read end sets interrupt flag on phase four after next phase two
// - output-full stays low after a read until firmware writes port D
// - input-full and output-full are held clear while mode is disabled
// - input-overrun is never cleared by hardware, only by firmware zero write
// - interrupt flag latched until cleared; request only while enabled
// - external accesses are asynchronous, driven only by strobe levels
// - output-full reads 1 while a firmware byte awaits the external read
// - read strobe low with chip select low means a read of port D
module pslv_parallel_slave_port (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] portDIn,
	output logic [7:0] portDOut,
	output logic [7:0] portDOe,
	input wire logic [2:0] portEIn,
	output logic [2:0] portEOut,
	output logic [2:0] portEOe,
	output logic slavePortIrq
);
	// ****************************************
	// state
	// ****************************************
	logic [7:0] dSync [pslv_pkg::SYNC_STAGES];
	logic [2:0] eSync [pslv_pkg::SYNC_STAGES];
	logic [2:0] eLevel;
	logic wrActPrev;
	logic rdActPrev;
	logic [7:0] inLatch;
	logic [7:0] outLatch;
	logic [7:0] dirD;
	logic [2:0] outE;
	logic [2:0] dirE;
	logic modeOn;
	logic inputFull;
	logic outputFull;
	logic overrun;
	logic [7:0] irqFlags;
	logic [7:0] irqEnables;
	logic [7:0] convCfg;
	pslv_pkg::pslv_phase_t phase;
	logic wrPend;
	logic wrArmed;
	logic rdPend;
	logic rdArmed;

	logic csLow;
	logic wrLow;
	logic rdLow;
	logic wrAct;
	logic rdAct;
	logic wrStart;
	logic wrEnd;
	logic rdStart;
	logic rdEnd;
	logic wrDone;
	logic rdDone;
	logic setup;
	logic access;
	logic [9:0] idx;
	logic fwWrite;
	logic fwReadD;
	logic fwWriteD;
	logic fwWriteCtrl;
	logic fwWriteFlags;
	logic mapped;
	logic [7:0] next_rdata;

	// ****************************************
	// pin synchronisers
	// ****************************************
	// three stages; the first feeds only the second
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < pslv_pkg::SYNC_STAGES; i++) begin
				dSync[i] <= 8'h00;
				eSync[i] <= 3'h7;
			end
		end else begin
			dSync[0] <= portDIn;
			eSync[0] <= portEIn;
			for (int i = 1; i < pslv_pkg::SYNC_STAGES; i++) begin
				dSync[i] <= dSync[i-1];
				eSync[i] <= eSync[i-1];
			end
		end
	end

	// strobe level follows once the last two stages agree, filtering glitches
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			eLevel <= 3'h7;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (eSync[1][i] == eSync[2][i]) begin
					eLevel[i] <= eSync[2][i];
				end
			end
		end
	end

	assign csLow = !eLevel[pslv_pkg::PIN_CHIP_SELECT];
	assign wrLow = !eLevel[pslv_pkg::PIN_WRITE_STROBE];
	assign rdLow = !eLevel[pslv_pkg::PIN_READ_STROBE];
	assign wrAct = modeOn && csLow && wrLow;
	assign rdAct = modeOn && csLow && rdLow;
	assign wrStart = wrAct && !wrActPrev;
	assign wrEnd = !wrAct && wrActPrev;
	assign rdStart = rdAct && !rdActPrev;
	assign rdEnd = !rdAct && rdActPrev;

	// edge history of the decoded strobes
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wrActPrev <= 1'b0;
			rdActPrev <= 1'b0;
		end else begin
			wrActPrev <= wrAct;
			rdActPrev <= rdAct;
		end
	end

	// ****************************************
	// instruction phase and completion timing
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			phase <= pslv_pkg::PSLV_PH_ONE;
		end else begin
			case (phase)
				pslv_pkg::PSLV_PH_ONE: phase <= pslv_pkg::PSLV_PH_TWO;
				pslv_pkg::PSLV_PH_TWO: phase <= pslv_pkg::PSLV_PH_THREE;
				pslv_pkg::PSLV_PH_THREE: phase <= pslv_pkg::PSLV_PH_FOUR;
				pslv_pkg::PSLV_PH_FOUR: phase <= pslv_pkg::PSLV_PH_ONE;
				default: phase <= pslv_pkg::PSLV_PH_ONE;
			endcase
		end
	end

	assign wrDone = wrPend && wrArmed && phase == pslv_pkg::PSLV_PH_FOUR;
	assign rdDone = rdPend && rdArmed && phase == pslv_pkg::PSLV_PH_FOUR;

	// a finished strobe waits for a phase two, then completes at phase four
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wrPend <= 1'b0;
			wrArmed <= 1'b0;
			rdPend <= 1'b0;
			rdArmed <= 1'b0;
		end else begin
			wrPend <= wrEnd || (wrPend && !wrDone);
			wrArmed <= wrPend && !wrDone && (wrArmed || phase == pslv_pkg::PSLV_PH_TWO);
			rdPend <= rdEnd || (rdPend && !rdDone);
			rdArmed <= rdPend && !rdDone && (rdArmed || phase == pslv_pkg::PSLV_PH_TWO);
		end
	end

	// ****************************************
	// apb decode
	// ****************************************
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign idx = paddr[11:2];
	assign fwWrite = access && pwrite && pstrb[0];
	assign fwReadD = access && !pwrite && idx == pslv_pkg::IDX_PORT_D_LATCH;
	assign fwWriteD = fwWrite && idx == pslv_pkg::IDX_PORT_D_LATCH;
	assign fwWriteCtrl = fwWrite && idx == pslv_pkg::IDX_PORT_E_CTRL;
	assign fwWriteFlags = fwWrite && idx == pslv_pkg::IDX_IRQ_FLAGS;

	always_comb begin
		mapped = 1'b1;
		next_rdata = 8'h00;
		case (idx)
			pslv_pkg::IDX_PORT_D_LATCH: next_rdata = modeOn ? inLatch : dSync[2];
			pslv_pkg::IDX_PORT_E_PINS: next_rdata = {5'h00, eSync[2]};
			pslv_pkg::IDX_IRQ_FLAGS: next_rdata = irqFlags;
			pslv_pkg::IDX_PORT_D_DIRECTION: next_rdata = dirD;
			pslv_pkg::IDX_PORT_E_CTRL: next_rdata = {inputFull, outputFull, overrun,
				modeOn, 1'b0, dirE};
			pslv_pkg::IDX_IRQ_ENABLES: next_rdata = irqEnables;
			pslv_pkg::IDX_CONVERTER_CONFIG: next_rdata = convCfg;
			default: mapped = 1'b0;
		endcase
	end

	// one wait-free access phase; answer prepared during setup
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= setup && !pwrite ? {24'h000000, next_rdata} : 32'h00000000;
		end
	end

	// ****************************************
	// firmware-owned registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			outLatch <= 8'h00;
			dirD <= pslv_pkg::RST_PORT_D_DIRECTION;
			outE <= 3'h0;
			dirE <= pslv_pkg::RST_PORT_E_DIRECTION;
			modeOn <= 1'b0;
			irqEnables <= pslv_pkg::RST_IRQ_ENABLES;
			convCfg <= pslv_pkg::RST_CONVERTER_CONFIG;
		end else if (fwWrite) begin
			case (idx)
				pslv_pkg::IDX_PORT_D_LATCH: outLatch <= pwdata[7:0];
				pslv_pkg::IDX_PORT_E_PINS: outE <= pwdata[2:0];
				pslv_pkg::IDX_PORT_D_DIRECTION: dirD <= pwdata[7:0];
				pslv_pkg::IDX_PORT_E_CTRL: begin
					dirE <= pwdata[2:0];
					modeOn <= pwdata[pslv_pkg::BIT_SLAVE_PORT_ENABLE];
				end
				pslv_pkg::IDX_IRQ_ENABLES: irqEnables <= pwdata[7:0];
				pslv_pkg::IDX_CONVERTER_CONFIG: convCfg <= pwdata[7:0] & pslv_pkg::CONVERTER_CONFIG_MASK;
				default: ;
			endcase
		end
	end

	// ****************************************
	// slave-port latches and status flags
	// ****************************************
	// capture at strobe end, when the master's byte has certainly settled
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			inLatch <= 8'h00;
		end else if (wrEnd) begin
			inLatch <= dSync[2];
		end
	end

	// in every flag the hardware set wins over a same-cycle firmware clear; mode-off still clears input full
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			inputFull <= 1'b0;
		end else if (!modeOn) begin
			inputFull <= 1'b0;
		end else if (wrDone) begin
			inputFull <= 1'b1;
		end else if (fwReadD) begin
			inputFull <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			outputFull <= 1'b0;
		end else if (!modeOn) begin
			outputFull <= 1'b0;
		end else if (fwWriteD) begin
			outputFull <= 1'b1;
		end else if (rdStart) begin
			outputFull <= 1'b0;
		end
	end

	// overrun survives mode changes; only a firmware zero write clears it
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			overrun <= 1'b0;
		end else if (wrStart && inputFull) begin
			overrun <= 1'b1;
		end else if (fwWriteCtrl) begin
			overrun <= overrun && pwdata[pslv_pkg::BIT_INPUT_OVERRUN];
		end
	end

	// only the slave-port bit is hardware-set; the others are plain storage
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			irqFlags <= pslv_pkg::RST_IRQ_FLAGS;
		end else begin
			if (fwWriteFlags) begin
				irqFlags <= pwdata[7:0];
			end
			if (wrDone || rdDone) begin
				irqFlags[pslv_pkg::BIT_SLAVE_PORT_IRQ] <= 1'b1;
			end
		end
	end

	// ****************************************
	// pin drivers and interrupt request
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			portDOut <= 8'h00;
			portDOe <= 8'h00;
			portEOut <= 3'h0;
			portEOe <= 3'h0;
			slavePortIrq <= 1'b0;
		end else begin
			portDOut <= outLatch;
			// direction register is bypassed; the master's strobes decide
			portDOe <= modeOn ? {8{rdAct}} : ~dirD;
			portEOut <= outE;
			portEOe <= modeOn ? 3'h0 : ~dirE;
			slavePortIrq <= irqFlags[pslv_pkg::BIT_SLAVE_PORT_IRQ]
				&& irqEnables[pslv_pkg::BIT_SLAVE_PORT_IRQ];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence s_wrEnd;
		modeOn && wrEnd;
	endsequence

	sequence s_rdEnd;
		modeOn && rdEnd;
	endsequence

	property p_full_after_write;
		@(posedge core_clk) disable iff (!nrst)
		s_wrEnd |-> ##[1:7] wrDone ##1 (inputFull || !$past(modeOn));
	endproperty
	a_full_after_write: assert property (p_full_after_write) else $error("input full late");

	property p_irq_with_full;
		@(posedge core_clk) disable iff (!nrst)
		$rose(inputFull) |-> irqFlags[pslv_pkg::BIT_SLAVE_PORT_IRQ];
	endproperty
	a_irq_with_full: assert property (p_irq_with_full) else $error("flag not set with input full");

	property p_full_clear_cause;
		@(posedge core_clk) disable iff (!nrst)
		$fell(inputFull) |-> $past(fwReadD) || !$past(modeOn);
	endproperty
	a_full_clear_cause: assert property (p_full_clear_cause) else $error("input full cleared wrongly");

	property p_overrun_set;
		@(posedge core_clk) disable iff (!nrst)
		wrStart && inputFull |=> overrun;
	endproperty
	a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

	property p_overrun_hold;
		@(posedge core_clk) disable iff (!nrst)
		overrun && !fwWriteCtrl |=> overrun;
	endproperty
	a_overrun_hold: assert property (p_overrun_hold) else $error("overrun lost");

	property p_outfull_clear;
		@(posedge core_clk) disable iff (!nrst)
		rdStart && !fwWriteD |=> !outputFull;
	endproperty
	a_outfull_clear: assert property (p_outfull_clear) else $error("output full kept");

	property p_read_irq;
		@(posedge core_clk) disable iff (!nrst)
		s_rdEnd |-> ##[2:8] irqFlags[pslv_pkg::BIT_SLAVE_PORT_IRQ] || fwWriteFlags;
	endproperty
	a_read_irq: assert property (p_read_irq) else $error("read completion flag missing");

	property p_flags_clear_off;
		@(posedge core_clk) disable iff (!nrst)
		!modeOn |=> !inputFull && !outputFull;
	endproperty
	a_flags_clear_off: assert property (p_flags_clear_off) else $error("flags set while off");

	property p_drive_read;
		@(posedge core_clk) disable iff (!nrst)
		modeOn |=> portDOe == {8{$past(rdAct)}};
	endproperty
	a_drive_read: assert property (p_drive_read) else $error("port D drive wrong");

	property p_irq_gate;
		@(posedge core_clk) disable iff (!nrst)
		slavePortIrq |-> $past(irqEnables[pslv_pkg::BIT_SLAVE_PORT_IRQ]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");
endmodule : pslv_parallel_slave_port

// ### shared/pslv_pkg.sv
// constants, register map and phase encoding for the parallel slave port
package pslv_pkg;
	// ****************************************
	// register indices (byte address is four times the index)
	// ****************************************
	localparam logic [9:0] IDX_PORT_D_LATCH = 10'h008;
	localparam logic [9:0] IDX_PORT_E_PINS = 10'h009;
	localparam logic [9:0] IDX_IRQ_FLAGS = 10'h00c;
	localparam logic [9:0] IDX_PORT_D_DIRECTION = 10'h088;
	localparam logic [9:0] IDX_PORT_E_CTRL = 10'h089;
	localparam logic [9:0] IDX_IRQ_ENABLES = 10'h08c;
	localparam logic [9:0] IDX_CONVERTER_CONFIG = 10'h09f;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_INPUT_FULL = 7;
	localparam int BIT_OUTPUT_FULL = 6;
	localparam int BIT_INPUT_OVERRUN = 5;
	localparam int BIT_SLAVE_PORT_ENABLE = 4;
	localparam int BIT_SLAVE_PORT_IRQ = 7;
	localparam int PIN_READ_STROBE = 0;
	localparam int PIN_WRITE_STROBE = 1;
	localparam int PIN_CHIP_SELECT = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [2:0] RST_PORT_E_DIRECTION = 3'h7;
	localparam logic [7:0] RST_PORT_D_DIRECTION = 8'hff;
	localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
	localparam logic [7:0] RST_CONVERTER_CONFIG = 8'h00;
	localparam logic [7:0] CONVERTER_CONFIG_MASK = 8'h8f;

	// ****************************************
	// timing
	// ****************************************
	localparam int SYNC_STAGES = 3;
	localparam int COMPLETION_MAX_CYCLES = 8;

	// instruction cycle phases, one core clock each
	typedef enum logic [1:0] {
		PSLV_PH_ONE = 2'b00,
		PSLV_PH_TWO = 2'b01,
		PSLV_PH_THREE = 2'b10,
		PSLV_PH_FOUR = 2'b11
	} pslv_phase_t;
endpackage : pslv_pkg

// ### bench/pslv_ext_master.sv
// external 8-bit bus master that drives the slave port strobes and data pins
module pslv_ext_master (
	input wire logic core_clk,
	input wire logic [7:0] portDWire,
	output logic [2:0] strobeN,
	output logic [7:0] dataDrv
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// pin idle state
	// ****************************************
	// strobes idle high (not selected); data starts as all zeros
	initial begin
		strobeN = 3'h7;
		dataDrv = 8'h00;
	end

	// ****************************************
	// bus cycles
	// ****************************************
	// write: select and write strobe low together, byte held across the rising edge
	task automatic extWrite(input logic [7:0] value);
		strobeN <= 3'b001;
		dataDrv <= value;
		repeat (6) @(posedge core_clk);
		strobeN <= 3'h7;
		repeat (4) @(posedge core_clk);
		// released bus shows the inverse so a stale byte cannot pass for fresh data
		dataDrv <= ~value;
		@(posedge core_clk);
	endtask : extWrite

	// read: select and read strobe low; byte taken from the wire before release
	task automatic extRead(output logic [7:0] value);
		strobeN <= 3'b010;
		repeat (7) @(posedge core_clk);
		value = portDWire;
		strobeN <= 3'h7;
		@(posedge core_clk);
	endtask : extRead
endmodule : pslv_ext_master

// ### bench/pslv_parallel_slave_port_bench.sv
// self-checking bench for the parallel slave port: apb firmware plus external master
module pslv_parallel_slave_port_bench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [9:0] PD = pslv_pkg::IDX_PORT_D_LATCH;
	localparam logic [9:0] PE = pslv_pkg::IDX_PORT_E_PINS;
	localparam logic [9:0] FLG = pslv_pkg::IDX_IRQ_FLAGS;
	localparam logic [9:0] DDIR = pslv_pkg::IDX_PORT_D_DIRECTION;
	localparam logic [9:0] CTRL = pslv_pkg::IDX_PORT_E_CTRL;
	localparam logic [9:0] ENA = pslv_pkg::IDX_IRQ_ENABLES;
	localparam logic [9:0] CFG = pslv_pkg::IDX_CONVERTER_CONFIG;

	logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, slavePortIrq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, lastRd;
	logic [3:0] pstrb;
	logic [7:0] portDIn, portDOut, portDOe, dataDrv, got;
	logic [2:0] portEIn, portEOut, portEOe, strobeN;
	logic lastErr;
	int badCount, nCompared, cycles;

	// ****************************************
	// clock, pins and instances
	// ****************************************
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	// each pin is the device's value where it drives, else the external master's
	assign portDIn = (portDOe & portDOut) | (~portDOe & dataDrv);
	assign portEIn = (portEOe & portEOut) | (~portEOe & strobeN);

	pslv_parallel_slave_port u_pslv_parallel_slave_port (.core_clk(core_clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe), .portEIn(portEIn),
		.portEOut(portEOut), .portEOe(portEOe), .slavePortIrq(slavePortIrq));

	pslv_ext_master u_pslv_ext_master (.core_clk(core_clk), .portDWire(portDIn),
		.strobeN(strobeN), .dataDrv(dataDrv));

	// ****************************************
	// tasks
	// ****************************************
	task automatic finishTest;
		$display("compared %0d, mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finishTest

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			badCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; entered just after a rising edge, leaves one edge after release
	task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= {idx, 2'b00};
		pwrite <= wr;
		pwdata <= {24'h000000, wd};
		pstrb <= 4'h1;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		lastRd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : xfer

	task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
		xfer(idx, 1'b1, wd);
	endtask : wr

	task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
		xfer(idx, 1'b0, 8'h00);
		check(lastRd, {24'h000000, exp});
	endtask : rd

	// ****************************************
	// hang guard
	// ****************************************
	// whole run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			badCount++;
			finishTest;
		end
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
		badCount = 0;
		nCompared = 0;
		cycles = 0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		// reset values and an unmapped address
		rd(CTRL, 8'h07);
		rd(FLG, 8'h00);
		rd(ENA, 8'h00);
		xfer(10'h3ff, 1'b0, 8'h00);
		check(32'(lastErr), 32'h00000001);
		check(32'(portDOe), 32'h00000000);
		// strobes have no effect while the port mode is off
		u_pslv_ext_master.extWrite(8'h11);
		repeat (12) @(posedge core_clk);
		rd(CTRL, 8'h07);
		rd(FLG, 8'h00);
		// general-purpose mode: port E pins follow their latch and direction
		wr(PE, 8'h05);
		wr(CTRL, 8'h00);
		repeat (4) @(posedge core_clk);
		check(32'(portEOut), 32'h00000005);
		check(32'(portEOe), 32'h00000007);
		rd(PE, 8'h05);
		// firmware setup: strobe pins digital inputs, then port mode on
		wr(CFG, 8'h0f);
		rd(CFG, 8'h0f);
		wr(CTRL, 8'h17);
		wr(DDIR, 8'h00);
		check(32'(portDOe), 32'h00000000);
		check(32'(portEOe), 32'h00000000);
		// external write completes: input full and flag set, request masked
		u_pslv_ext_master.extWrite(8'ha5);
		repeat (12) @(posedge core_clk);
		rd(CTRL, 8'h97);
		rd(FLG, 8'h80);
		check(32'(slavePortIrq), 32'h00000000);
		wr(ENA, 8'h80);
		repeat (2) @(posedge core_clk);
		check(32'(slavePortIrq), 32'h00000001);
		// second write before the first byte was read
		u_pslv_ext_master.extWrite(8'h3c);
		repeat (12) @(posedge core_clk);
		rd(CTRL, 8'hb7);
		rd(PD, 8'h3c);
		rd(CTRL, 8'h37);
		wr(FLG, 8'h00);
		rd(FLG, 8'h00);
		repeat (2) @(posedge core_clk);
		check(32'(slavePortIrq), 32'h00000000);
		// firmware byte out, external read takes it
		wr(PD, 8'h5a);
		rd(CTRL, 8'h77);
		u_pslv_ext_master.extRead(got);
		check(32'(got), 32'h0000005a);
		repeat (12) @(posedge core_clk);
		check(32'(portDOe), 32'h00000000);
		rd(CTRL, 8'h37);
		rd(FLG, 8'h80);
		// leaving port mode clears the full flags but keeps the overrun flag
		wr(PD, 8'h66);
		u_pslv_ext_master.extWrite(8'h22);
		repeat (12) @(posedge core_clk);
		rd(CTRL, 8'hf7);
		wr(CTRL, 8'h27);
		rd(CTRL, 8'h27);
		wr(CTRL, 8'h07);
		rd(CTRL, 8'h07);
		finishTest;
	end
endmodule : pslv_parallel_slave_port_bench
